//--- shared/sbh_defs.svh
`ifndef SBH_DEFS_SVH
`define SBH_DEFS_SVH

// ==========================================================================
// Window placement and block codes
`define SBH_ADDR_BASE 16'h1004
`define SBH_WIN_WORDS 64
`define SBH_CODE_ERR 16'h26DE
`define SBH_CODE_TRD 16'h26F2
`define SBH_CODE_TSET 16'h26F3
`define SBH_CODE_WARM 16'h270E
`define SBH_CODE_COLD 16'h270F

// ==========================================================================
// Word indices inside the window
`define SBH_W_ID 6'h00
`define SBH_W_REQ_CNT 6'h01
`define SBH_W_REQ_START 6'h02
`define SBH_W_SET_FIRST 6'h01
`define SBH_STEP_CODE 7'h01
`define SBH_STEP_CNT 7'h02
`define SBH_STEP_START 7'h03
`define SBH_STEP_DATA 7'h04
`define SBH_STEP_TRD_LAST 7'h08
`define SBH_STEP_TIME_FIRST 7'h02

// ==========================================================================
// Error table limits
`define SBH_ERR_CNT_MIN 16'h0001
`define SBH_ERR_CNT_MAX 16'h003C
`define SBH_CMD_TOTAL 1000
`define SBH_CMD_TOTAL_MAX 1000

// ==========================================================================
// Time field limits and reset time
`define SBH_MONTH_MAX 16'h000C
`define SBH_DAY_MAX 16'h001F
`define SBH_HOUR_MAX 16'h0017
`define SBH_MIN_MAX 16'h003B
`define SBH_SEC_MAX 16'h003B
`define SBH_MS_MAX 16'h03E7
`define SBH_RST_YEAR 16'h07D0
`define SBH_RST_MONTH 16'h0001
`define SBH_RST_DAY 16'h0001

// ==========================================================================
// Timing
`define SBH_CLK_PERIOD_NS 100
`define SBH_MS_PERIOD_NS 1000000
`define SBH_CYC_PER_MS ((`SBH_MS_PERIOD_NS) / (`SBH_CLK_PERIOD_NS))

`endif

//--- shared/sbh_pkg.sv
`default_nettype none
`include "sbh_defs.svh"

package sbh_pkg;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_DECODE = 5'h02,
    ST_RESP = 5'h04,
    ST_WIPE = 5'h08,
    ST_DONE = 5'h10
  } sbh_state_e;

  // Year first, so word order of a block is MSB first
  typedef struct packed
  {
    logic [15:0] year;
    logic [15:0] month;
    logic [15:0] day;
    logic [15:0] hour;
    logic [15:0] minute;
    logic [15:0] second;
    logic [15:0] msec;
  } sbh_time_s;

  function automatic logic sbh_time_ok(input sbh_time_s t);
    sbh_time_ok = (t.month >= 16'h0001) && (t.month <= `SBH_MONTH_MAX) &&
      (t.day >= 16'h0001) && (t.day <= `SBH_DAY_MAX) &&
      (t.hour <= `SBH_HOUR_MAX) && (t.minute <= `SBH_MIN_MAX) &&
      (t.second <= `SBH_SEC_MAX) && (t.msec <= `SBH_MS_MAX);
  endfunction : sbh_time_ok

endpackage : sbh_pkg

`default_nettype wire

//--- shared/sbh_tod_if.sv
`default_nettype none

interface sbh_tod_if;
  logic set;
  sbh_pkg::sbh_time_s set_time;
  sbh_pkg::sbh_time_s now;

  modport keeper (input set, input set_time, output now);
  modport user (output set, output set_time, input now);
endinterface : sbh_tod_if

`default_nettype wire

//--- src/sbh_timekeeper.sv
`default_nettype none
`include "sbh_defs.svh"

module sbh_timekeeper #(
  parameter int CYC_PER_MS = `SBH_CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  sbh_tod_if.keeper tod
);

  localparam int CW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;

  if (CYC_PER_MS < 1)
  begin : g_chk
    $error("CYC_PER_MS must be at least one");
  end

  typedef struct packed
  {
    logic [CW-1:0] cyc;
    sbh_pkg::sbh_time_s now;
  } sbh_tk_s;

  sbh_tk_s q;
  sbh_tk_s n;

  // Days in month, leap years taken as every fourth year
  function automatic logic [15:0] sbh_month_days(input logic [15:0] y,
                                                 input logic [15:0] m);
    case (m)
      16'h0002: sbh_month_days = (y[1:0] == 2'h0) ? 16'h001D : 16'h001C;
      16'h0004, 16'h0006, 16'h0009, 16'h000B: sbh_month_days = 16'h001E;
      default: sbh_month_days = `SBH_DAY_MAX;
    endcase
  endfunction : sbh_month_days

  // ==========================================================================
  // Millisecond tick and calendar roll-over
  always_comb
  begin
    n = q;
    if (tod.set)
    begin
      n.now = tod.set_time;
      n.cyc = '0;
    end
    else if (q.cyc != CW'(CYC_PER_MS - 1))
    begin
      n.cyc = q.cyc + CW'(1);
    end
    else
    begin
      // Carry chain keeps every field inside its range R11
      n.cyc = '0;
      n.now.msec = q.now.msec + 16'h0001;
      if (q.now.msec >= `SBH_MS_MAX)
      begin
        n.now.msec = 16'h0000;
        n.now.second = q.now.second + 16'h0001;
        if (q.now.second >= `SBH_SEC_MAX)
        begin
          n.now.second = 16'h0000;
          n.now.minute = q.now.minute + 16'h0001;
          if (q.now.minute >= `SBH_MIN_MAX)
          begin
            n.now.minute = 16'h0000;
            n.now.hour = q.now.hour + 16'h0001;
            if (q.now.hour >= `SBH_HOUR_MAX)
            begin
              n.now.hour = 16'h0000;
              n.now.day = q.now.day + 16'h0001;
              if (q.now.day >= sbh_month_days(q.now.year, q.now.month))
              begin
                n.now.day = 16'h0001;
                n.now.month = q.now.month + 16'h0001;
                if (q.now.month >= `SBH_MONTH_MAX)
                begin
                  n.now.month = 16'h0001;
                  n.now.year = q.now.year + 16'h0001;
                end
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '{cyc: '0, now: '{year: `SBH_RST_YEAR, month: `SBH_RST_MONTH,
             day: `SBH_RST_DAY, default: 16'h0000}};
    end
    else
    begin
      q <= n;
    end
  end

  assign tod.now = q.now;

  // ==========================================================================
  // Checks
  AST_TOD_RANGE: assert property ( // R11
    @(posedge clk_sys) disable iff (!arst_n) sbh_pkg::sbh_time_ok(q.now))
    else $error("Clock field left its range");

  AST_TOD_SET: assert property ( // R13
    @(posedge clk_sys) disable iff (!arst_n)
    tod.set |=> (q.now == $past(tod.set_time)) && (q.cyc == '0))
    else $error("Clock did not take the set time");

endmodule : sbh_timekeeper

`default_nettype wire

//--- src/sbh_top.sv
`default_nettype none
`include "sbh_defs.svh"

// Operation
// R01 - Processor writes code 9950 into word 4100
// R02 - Request count in 4101, 1 to 60
// R03 - Start index in 4102, below command total
// R04 - Keep one error entry per command
// R05 - Only valid requests get a response
// R06 - Response ends with zero in 4100
// R07 - Error reply: code, count, start index
// R08 - Words 4104 onward: consecutive latest errors
// R09 - Time read is a one-word 9970 block
// R10 - Time reply: code then seven date fields
// R11 - Time fields stay within their ranges
// R12 - Clock set: 9971 then seven fields
// R13 - Clock set loads clock, clears 4100
// R14 - Code 9998 triggers warm boot
// R15 - Code 9999 triggers cold boot
// R16 - Warm and cold boot act alike
// R17 - Bad error request is silently ignored
module sbh_top #(
  parameter int CMD_TOTAL = `SBH_CMD_TOTAL,
  parameter int CYC_PER_MS = `SBH_CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic bp_we,
  input wire logic bp_re,
  input wire logic [15:0] bp_addr,
  input wire logic [15:0] bp_wdata,
  output logic [15:0] bp_rdata,
  output logic busy,
  output logic boot_pulse,
  input wire logic err_we,
  input wire logic [15:0] err_idx,
  input wire logic [15:0] err_val
);

  localparam int IW = $clog2(CMD_TOTAL);

  if (CMD_TOTAL < 2 || CMD_TOTAL > `SBH_CMD_TOTAL_MAX)
  begin : g_chk
    $error("CMD_TOTAL must lie in 2 to 1000");
  end

  typedef struct packed
  {
    sbh_pkg::sbh_state_e st;
    logic [15:0] code;
    logic [6:0] step;
    logic [6:0] last;
    logic [15:0] cnt;
    logic [15:0] start;
    logic [IW-1:0] wipe;
    logic busy;
    logic boot;
    logic tod_set;
    sbh_pkg::sbh_time_s set_time;
    logic [15:0] rdata;
  } sbh_ctl_s;

  sbh_ctl_s q;
  sbh_ctl_s n;
  sbh_tod_if tod ();

  logic [15:0] win_mem [`SBH_WIN_WORDS];
  logic [15:0] err_mem [CMD_TOTAL];

  logic [15:0] off;
  logic in_win;
  logic [15:0] req_cnt;
  logic [15:0] req_start;
  logic req_ok;
  sbh_pkg::sbh_time_s req_time;
  logic [6:0][15:0] now_w;
  logic [15:0] rd_pos;
  logic [15:0] rd_val;
  logic [15:0] resp_word;
  logic dev_we;
  logic [5:0] dev_idx;
  logic [15:0] dev_val;

  // ==========================================================================
  // Window decode and request fields
  assign off = bp_addr - `SBH_ADDR_BASE;
  assign in_win = off < 16'(`SBH_WIN_WORDS);
  assign req_cnt = win_mem[`SBH_W_REQ_CNT];
  assign req_start = win_mem[`SBH_W_REQ_START];
  assign req_ok = (req_cnt >= `SBH_ERR_CNT_MIN) && // R02
    (req_cnt <= `SBH_ERR_CNT_MAX) &&
    (req_start < 16'(CMD_TOTAL)); // R03

  generate
    for (genvar i = 0; i < 7; i++)
    begin : g_set
      // Field i of the set block sits in window word 1 + i R12
      assign req_time[16*(6-i) +: 16] = win_mem[`SBH_W_SET_FIRST + 6'(i)];
    end
  endgenerate

  assign now_w = q.set_time;

  // ==========================================================================
  // Response word for the current step
  always_comb
  begin
    rd_pos = q.start + 16'(q.step) - 16'(`SBH_STEP_DATA);
    rd_val = 16'h0000;
    if (rd_pos < 16'(CMD_TOTAL))
    begin
      rd_val = err_mem[rd_pos[IW-1:0]]; // R08
    end
    if (q.step == `SBH_STEP_CODE)
    begin
      resp_word = q.code; // R07 R10
    end
    else if (q.code == `SBH_CODE_ERR)
    begin
      if (q.step == `SBH_STEP_CNT)
      begin
        resp_word = q.cnt; // R07
      end
      else if (q.step == `SBH_STEP_START)
      begin
        resp_word = q.start; // R07
      end
      else
      begin
        resp_word = rd_val; // R08
      end
    end
    else
    begin
      resp_word = now_w[3'(`SBH_STEP_TRD_LAST - q.step)]; // R10
    end
  end

  // ==========================================================================
  // Block sequencer
  always_comb
  begin
    n = q;
    n.boot = 1'b0;
    n.tod_set = 1'b0;
    dev_we = 1'b0;
    dev_idx = `SBH_W_ID;
    dev_val = 16'h0000;
    if (bp_re)
    begin
      n.rdata = in_win ? win_mem[off[5:0]] : 16'h0000;
    end
    case (q.st)
      sbh_pkg::ST_IDLE:
      begin
        // A nonzero id written to the first word starts a block R01 R09
        if (bp_we && in_win && off[5:0] == `SBH_W_ID && bp_wdata != '0)
        begin
          n.code = bp_wdata;
          n.busy = 1'b1;
          n.st = sbh_pkg::ST_DECODE;
        end
      end
      sbh_pkg::ST_DECODE:
      begin
        n.st = sbh_pkg::ST_IDLE;
        n.busy = 1'b0;
        case (q.code)
          `SBH_CODE_ERR:
          begin
            if (req_ok) // R05 R17
            begin
              n.cnt = req_cnt;
              n.start = req_start;
              n.step = `SBH_STEP_CODE;
              n.last = req_cnt[6:0] + `SBH_STEP_START;
              n.busy = 1'b1;
              n.st = sbh_pkg::ST_RESP;
            end
          end
          `SBH_CODE_TRD:
          begin
            // Snapshot, so no field rolls over while the reply goes out
            n.set_time = tod.now; // R10
            n.step = `SBH_STEP_CODE;
            n.last = `SBH_STEP_TRD_LAST;
            n.busy = 1'b1;
            n.st = sbh_pkg::ST_RESP;
          end
          `SBH_CODE_TSET:
          begin
            // A set with any field out of range is dropped whole, the block still completes
            n.tod_set = sbh_pkg::sbh_time_ok(req_time); // R11 R13
            n.set_time = req_time;
            n.busy = 1'b1;
            n.st = sbh_pkg::ST_DONE;
          end
          `SBH_CODE_WARM, `SBH_CODE_COLD:
          begin
            // Both boots share one path R14 R15 R16
            n.boot = 1'b1;
            n.wipe = '0;
            n.busy = 1'b1;
            n.st = sbh_pkg::ST_WIPE;
          end
          default:
          begin
            n.st = sbh_pkg::ST_IDLE;
          end
        endcase
      end
      sbh_pkg::ST_RESP:
      begin
        dev_we = 1'b1;
        dev_idx = q.step[5:0];
        dev_val = resp_word;
        n.step = q.step + 7'h01;
        if (q.step == q.last)
        begin
          n.st = sbh_pkg::ST_DONE;
        end
      end
      sbh_pkg::ST_WIPE:
      begin
        // Error store cleared one entry a cycle on reinitialisation R16
        n.wipe = q.wipe + IW'(1);
        if (q.wipe == IW'(CMD_TOTAL - 1))
        begin
          n.st = sbh_pkg::ST_DONE;
        end
      end
      sbh_pkg::ST_DONE:
      begin
        dev_we = 1'b1; // R06 R13
        n.busy = 1'b0;
        n.st = sbh_pkg::ST_IDLE;
      end
      default:
      begin
        n.busy = 1'b0;
        n.st = sbh_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '{st: sbh_pkg::ST_IDLE, set_time: '0, default: '0};
    end
    else
    begin
      q <= n;
    end
  end

  // ==========================================================================
  // Memories; block writes win, processor writes are refused while busy
  always_ff @(posedge clk_sys)
  begin
    if (dev_we)
    begin
      win_mem[dev_idx] <= dev_val;
    end
    else if (bp_we && in_win && !q.busy)
    begin
      win_mem[off[5:0]] <= bp_wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (q.st == sbh_pkg::ST_WIPE)
    begin
      err_mem[q.wipe] <= 16'h0000;
    end
    else if (err_we && err_idx < 16'(CMD_TOTAL))
    begin
      err_mem[err_idx[IW-1:0]] <= err_val; // R04
    end
  end

  assign tod.set = q.tod_set;
  assign tod.set_time = q.set_time;

  sbh_timekeeper #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_clock (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tod(tod)
  );

  assign bp_rdata = q.rdata;
  assign busy = q.busy;
  assign boot_pulse = q.boot;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_DONE_ZERO: assert property ( // R06
    dev_we && dev_idx == `SBH_W_ID |-> dev_val == 16'h0000 &&
    q.st == sbh_pkg::ST_DONE ##1 q.st == sbh_pkg::ST_IDLE && !q.busy)
    else $error("Completion word not zero or not last");

  AST_ERR_HEAD: assert property ( // R07
    q.st == sbh_pkg::ST_RESP && q.code == `SBH_CODE_ERR &&
    q.step == `SBH_STEP_CODE |-> dev_val == `SBH_CODE_ERR
    ##1 dev_idx == 6'h02 && dev_val == q.cnt
    ##1 dev_idx == 6'h03 && dev_val == q.start)
    else $error("Error reply header wrong");

  AST_ERR_LEN: assert property ( // R08
    $rose(q.st == sbh_pkg::ST_RESP) && q.code == `SBH_CODE_ERR |->
    (q.st == sbh_pkg::ST_RESP throughout
    ##[3:62] (dev_idx == 6'(q.cnt + 16'h0003))) ##1
    q.st == sbh_pkg::ST_DONE)
    else $error("Error reply length differs from count");

  AST_TRD_BODY: assert property ( // R10
    q.st == sbh_pkg::ST_RESP && q.code == `SBH_CODE_TRD &&
    q.step == `SBH_STEP_TIME_FIRST |-> dev_val == q.set_time.year
    ##6 dev_idx == 6'h08 && dev_val == q.set_time.msec
    ##1 q.st == sbh_pkg::ST_DONE)
    else $error("Time reply body wrong");

  AST_BAD_REQ: assert property ( // R17
    q.st == sbh_pkg::ST_DECODE && q.code == `SBH_CODE_ERR && !req_ok
    |=> q.st == sbh_pkg::ST_IDLE && !dev_we && !q.busy)
    else $error("Bad error request was answered");

  AST_SET_NORESP: assert property ( // R13
    q.st == sbh_pkg::ST_DECODE && q.code == `SBH_CODE_TSET |=>
    q.tod_set == sbh_pkg::sbh_time_ok($past(req_time)) && dev_we &&
    dev_idx == `SBH_W_ID)
    else $error("Clock set block mishandled");

  AST_BOOT: assert property ( // R14
    q.st == sbh_pkg::ST_DECODE &&
    (q.code == `SBH_CODE_WARM || q.code == `SBH_CODE_COLD) |=>
    boot_pulse && q.st == sbh_pkg::ST_WIPE ##1 !boot_pulse)
    else $error("Boot block gave no boot pulse");

  AST_WIPE_END: assert property ( // R16
    boot_pulse |-> ##[1:1000] q.st == sbh_pkg::ST_DONE)
    else $error("Reinitialisation did not finish");

  AST_ONLY_VALID: assert property ( // R05
    $rose(q.st == sbh_pkg::ST_RESP) |-> $past(q.code) == `SBH_CODE_TRD ||
    ($past(q.code) == `SBH_CODE_ERR && $past(req_ok)))
    else $error("Response for an invalid block");

  COV_ERR: cover property (q.st == sbh_pkg::ST_RESP &&
    q.code == `SBH_CODE_ERR ##[1:63] q.st == sbh_pkg::ST_DONE);
  COV_TRD: cover property (q.st == sbh_pkg::ST_RESP &&
    q.code == `SBH_CODE_TRD && q.step == `SBH_STEP_TRD_LAST);
  COV_SET: cover property (q.tod_set);
  COV_BOOT: cover property (boot_pulse);

endmodule : sbh_top

`default_nettype wire

//--- test/sbh_proc_model.sv
`default_nettype none
`include "sbh_defs.svh"

// ==========================================================================
// Controlling processor on the shared word window
module sbh_proc_model (
  input wire logic clk_sys,
  output logic bp_we,
  output logic bp_re,
  output logic [15:0] bp_addr,
  output logic [15:0] bp_wdata,
  input wire logic [15:0] bp_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    bp_we = 1'b0;
    bp_re = 1'b0;
    bp_addr = 16'h0000;
    bp_wdata = 16'h0000;
  end

  // Released lines show the inverse, so a stale value never passes as fresh
  task automatic wr(input logic [15:0] off, input logic [15:0] d);
    @(negedge clk_sys);
    bp_we = 1'b1;
    bp_addr = `SBH_ADDR_BASE + off;
    bp_wdata = d;
    @(negedge clk_sys);
    bp_we = 1'b0;
    bp_addr = ~bp_addr;
    bp_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [15:0] off, output logic [15:0] d);
    @(negedge clk_sys);
    bp_re = 1'b1;
    bp_addr = `SBH_ADDR_BASE + off;
    @(negedge clk_sys);
    bp_re = 1'b0;
    bp_addr = ~bp_addr;
    d = bp_rdata;
  endtask : rd

  // Parameters go in before the id word, which starts the block
  task automatic send_err(input logic [15:0] cnt, input logic [15:0] st);
    wr(16'h0001, cnt);
    wr(16'h0002, st);
    wr(16'h0000, `SBH_CODE_ERR);
  endtask : send_err

  task automatic send_set(input sbh_pkg::sbh_time_s t);
    for (int i = 0; i < 7; i++)
    begin
      wr(16'(i + 1), t[111 - 16 * i -: 16]);
    end
    wr(16'h0000, `SBH_CODE_TSET);
  endtask : send_set

  task automatic send_one(input logic [15:0] code);
    wr(16'h0000, code);
  endtask : send_one
endmodule : sbh_proc_model

`default_nettype wire

//--- test/tb_top.sv
`default_nettype none
`include "sbh_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int CMDS = 8;

  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic err_we = 1'b0;
  logic [15:0] err_idx = 16'h0000;
  logic [15:0] err_val = 16'h0000;
  logic bp_we;
  logic bp_re;
  logic [15:0] bp_addr;
  logic [15:0] bp_wdata;
  logic [15:0] bp_rdata;
  logic busy;
  logic boot_pulse;
  int fails = 0;
  int compares = 0;
  int boots = 0;

  always #50 clk_sys = ~clk_sys;

  always @(negedge clk_sys)
  begin
    if (boot_pulse === 1'b1)
      boots++;
  end

  sbh_top #(.CMD_TOTAL(CMDS), .CYC_PER_MS(4)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .bp_we(bp_we), .bp_re(bp_re),
    .bp_addr(bp_addr), .bp_wdata(bp_wdata), .bp_rdata(bp_rdata),
    .busy(busy), .boot_pulse(boot_pulse), .err_we(err_we),
    .err_idx(err_idx), .err_val(err_val)
  );

  sbh_proc_model proc (
    .clk_sys(clk_sys), .bp_we(bp_we), .bp_re(bp_re), .bp_addr(bp_addr),
    .bp_wdata(bp_wdata), .bp_rdata(bp_rdata)
  );

  // ========================================================================
  // Checking helpers
  task automatic chk(input string n, input logic [15:0] got,
                     input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic chk_w(input string n, input logic [15:0] off,
                       input logic [15:0] exp);
    logic [15:0] d;
    proc.rd(off, d);
    chk(n, d, exp);
  endtask : chk_w

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("busy_wait", {15'h0000, n < 3000}, 16'h0001);
  endtask : wait_idle

  task automatic load_errs(input logic [15:0] base);
    for (int i = 0; i < CMDS; i++)
    begin
      @(negedge clk_sys);
      err_we = 1'b1;
      err_idx = 16'(i);
      err_val = base + 16'(i);
    end
    @(negedge clk_sys);
    err_we = 1'b0;
  endtask : load_errs

  // Entries past the command total come back as zero
  task automatic err_req(input logic [15:0] cnt, input logic [15:0] st,
                         input bit wiped);
    logic [15:0] e;
    proc.send_err(cnt, st);
    wait_idle();
    chk_w("done", 16'h0000, 16'h0000);
    chk_w("code", 16'h0001, `SBH_CODE_ERR);
    chk_w("count", 16'h0002, cnt);
    chk_w("start", 16'h0003, st);
    for (int i = 0; i < cnt; i++)
    begin
      e = (st + i < CMDS && !wiped) ? 16'hE000 + st + 16'(i) : 16'h0000;
      chk_w("entry", 16'(4 + i), e);
    end
  endtask : err_req

  // ========================================================================
  // Scenarios
  task automatic t_err_table;
    load_errs(16'hE000);
    err_req(16'h003C, 16'h0000, 1'b0);
    err_req(16'h0004, 16'h0006, 1'b0);
    err_req(16'h0001, 16'h0007, 1'b0);
  endtask : t_err_table

  // Refused requests leave the id word and the last reply's start index untouched
  task automatic t_err_bad;
    logic [15:0] bad [3][2];
    bad = '{'{16'h0000, 16'h0000}, '{16'h003D, 16'h0000},
            '{16'h0001, 16'(CMDS)}};
    for (int i = 0; i < 3; i++)
    begin
      proc.send_err(bad[i][0], bad[i][1]);
      wait_idle();
      chk_w("bad_id", 16'h0000, `SBH_CODE_ERR);
      chk_w("bad_start", 16'h0003, 16'h0007);
    end
  endtask : t_err_bad

  task automatic time_rd(input logic [15:0] y, input logic [15:0] mo,
                         input logic [15:0] d, input logic [15:0] ms_max);
    logic [15:0] w;
    proc.send_one(`SBH_CODE_TRD);
    wait_idle();
    chk_w("t_done", 16'h0000, 16'h0000);
    chk_w("t_code", 16'h0001, `SBH_CODE_TRD);
    chk_w("year", 16'h0002, y);
    chk_w("month", 16'h0003, mo);
    chk_w("day", 16'h0004, d);
    chk_w("hour", 16'h0005, 16'h0000);
    chk_w("minute", 16'h0006, 16'h0000);
    chk_w("second", 16'h0007, 16'h0000);
    proc.rd(16'h0008, w);
    chk("msec_range", {15'h0000, w <= ms_max}, 16'h0001);
  endtask : time_rd

  // Last millisecond of a year must roll every field over
  task automatic t_time;
    proc.send_set('{16'h07E8, 16'h000C, 16'h001F, 16'h0017, 16'h003B,
                    16'h003B, 16'h03E7});
    wait_idle();
    chk_w("set_done", 16'h0000, 16'h0000);
    // The set millisecond must pass before the reply snapshot is taken
    repeat (8) @(negedge clk_sys);
    time_rd(16'h07E9, 16'h0001, 16'h0001, 16'h0014);
    proc.send_set('{16'h0BB8, 16'h000D, 16'h0001, 16'h0000, 16'h0000,
                    16'h0000, 16'h0000});
    wait_idle();
    chk_w("bad_set_done", 16'h0000, 16'h0000);
    time_rd(16'h07E9, 16'h0001, 16'h0001, 16'h0064);
  endtask : t_time

  task automatic t_boot;
    logic [15:0] codes [2];
    int b0;
    codes = '{`SBH_CODE_WARM, `SBH_CODE_COLD};
    for (int i = 0; i < 2; i++)
    begin
      load_errs(16'hE000);
      b0 = boots;
      proc.send_one(codes[i]);
      wait_idle();
      chk_w("boot_done", 16'h0000, 16'h0000);
      chk("boot_pulses", 16'(boots - b0), 16'h0001);
      err_req(16'h0008, 16'h0000, 1'b1);
    end
  endtask : t_boot

  initial
  begin
    #(60000 * 100);
    fails++;
    $display("ERROR watchdog expected finish seen timeout");
    wrap_up();
  end

  initial
  begin
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    chk("rst_busy", {15'h0000, busy}, 16'h0000);
    chk("rst_boot", {15'h0000, boot_pulse}, 16'h0000);
    chk("rst_rdata", bp_rdata, 16'h0000);
    chk_w("outside", 16'h0040, 16'h0000);
    t_err_table();
    t_err_bad();
    t_time();
    t_boot();
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
